// file: usb_uart_bridge_core.sv
// serial bridge core: function-side registers, uart, flow control, sleep pins, gpio, descriptors
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
module usb_uart_bridge_core #(
    parameter int gpio_w = 4,
    parameter logic [15:0] vid_default = 16'h1234, // arbitrary identity value
    parameter logic [15:0] pid_default = 16'h5678 // arbitrary identity value
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register port (function controller side)
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // serial port
    output logic txd,
    input wire logic rxd,
    input wire logic cts_n,
    output logic rts_n,
    input wire logic dsr_n,
    output logic dtr_n,
    input wire logic dcd_n,
    input wire logic ri_n,
    // sleep indicators
    output logic suspend_out,
    output logic suspend_oe,
    output logic suspend_n_out,
    output logic suspend_n_oe,
    // general purpose pins
    input wire logic [gpio_w-1:0] gpio_in,
    output logic [gpio_w-1:0] gpio_out,
    output logic [gpio_w-1:0] gpio_oe
);
    typedef struct packed {
        logic configured;
        logic asleep;
        bridge_pkg::line_t line;
        logic [19:0] div;
        logic rts;
        logic dtr;
        logic [gpio_w-1:0] gpio_o;
        logic [gpio_w-1:0] gpio_d;
        logic [15:0] vid;
        logic [15:0] pid;
        logic [7:0] pattr;
        logic [7:0] pmax;
        logic [5:0] ser_len;
        logic [6:0] desc_len;
        logic programmed;
        logic locked;
        logic [31:0] rdata;
        // transmitter
        bridge_pkg::ser_t tst;
        logic [19:0] tcnt;
        logic [2:0] tbit;
        logic [1:0] thalf;
        logic [7:0] tsh;
        logic tpar;
        logic tline;
        logic [7:0] thold;
        logic tfull;
        // receiver
        bridge_pkg::ser_t rst;
        logic [19:0] rcnt;
        logic [2:0] rbit;
        logic [7:0] rsh;
        logic rpar;
        logic [7:0] rdat;
        logic rvalid;
        logic rerr;
        logic paused;
        // synchronisers
        logic [2:0][4:0] sync;
        logic [2:0][gpio_w-1:0] gsync;
        bridge_pkg::modem_in_t pins;
        logic [gpio_w-1:0] gpins;
    } state_t;

    state_t s_reg;
    state_t s_next;
    logic [3:0] nbits;
    logic stop_done;
    logic tx_allow;

    always_comb begin
        s_next = s_reg;
        nbits = 4'(s_reg.line.len) + 4'h5;
        tx_allow = 1'b1;
        stop_done = 1'b0;
        // three-stage pin capture, change accepted when stages two and three agree
        s_next.sync[0] = {rxd, cts_n, dsr_n, dcd_n, ri_n};
        s_next.sync[1] = s_reg.sync[0];
        s_next.sync[2] = s_reg.sync[1];
        if (s_reg.sync[1] == s_reg.sync[2]) begin
            s_next.pins = s_reg.sync[2];
        end
        s_next.gsync[0] = gpio_in;
        s_next.gsync[1] = s_reg.gsync[0];
        s_next.gsync[2] = s_reg.gsync[1];
        if (s_reg.gsync[1] == s_reg.gsync[2]) begin
            s_next.gpins = s_reg.gsync[2];
        end
        // flow control gate; modem inputs are active low
        case (s_reg.line.flow)
            bridge_pkg::flow_rts_cts: tx_allow = !s_reg.pins.cts_n;
            bridge_pkg::flow_dsr_dtr: tx_allow = !s_reg.pins.dsr_n;
            bridge_pkg::flow_xon_xoff: tx_allow = !s_reg.paused;
            default: tx_allow = 1'b1;
        endcase
        // register writes
        s_next.rdata = 32'h0;
        if (wr) begin
            if (addr == bridge_pkg::ctrl_off) begin
                if (wdata[bridge_pkg::ctl_config_done]) begin
                    s_next.configured = 1'b1;
                    s_next.asleep = 1'b0;
                end
                if (wdata[bridge_pkg::ctl_suspend]) begin
                    s_next.asleep = 1'b1;
                end
                if (wdata[bridge_pkg::ctl_resume] || wdata[bridge_pkg::ctl_bus_reset]) begin
                    s_next.asleep = !s_next.configured;
                end
                s_next.rts = wdata[bridge_pkg::ctl_rts];
                s_next.dtr = wdata[bridge_pkg::ctl_dtr];
            end else if (addr == bridge_pkg::line_off) begin
                s_next.line.len = wdata[bridge_pkg::len_lsb +: 2];
                s_next.line.parity = bridge_pkg::parity_t'(wdata[bridge_pkg::par_lsb +: 3]);
                s_next.line.flow = bridge_pkg::flow_t'(wdata[bridge_pkg::flow_lsb +: 2]);
                // one and a half stop bits only with 5-bit characters
                if (wdata[bridge_pkg::stop_lsb +: 2] == 2'b01 && wdata[bridge_pkg::len_lsb +: 2] != 2'b00) begin
                    s_next.line.stop = bridge_pkg::stop_one;
                end else if (wdata[bridge_pkg::stop_lsb +: 2] == 2'b11) begin
                    s_next.line.stop = bridge_pkg::stop_two;
                end else begin
                    s_next.line.stop = bridge_pkg::stop_t'(wdata[bridge_pkg::stop_lsb +: 2]);
                end
            end else if (addr == bridge_pkg::baud_off) begin
                // divider = clk / baud; the fastest divider refused below 7 bits
                if (wdata[19:0] >= 20'(bridge_pkg::clk_hz / bridge_pkg::baud_fast) + 20'h1
                    || s_reg.line.len[1]) begin
                    s_next.div = wdata[19:0];
                end
            end else if (addr == bridge_pkg::data_off) begin
                if (!s_reg.tfull) begin
                    s_next.thold = wdata[7:0];
                    s_next.tfull = 1'b1;
                end
            end else if (addr == bridge_pkg::gpio_off) begin
                s_next.gpio_o = wdata[gpio_w-1:0];
                s_next.gpio_d = wdata[8 +: gpio_w];
            end else if (addr == bridge_pkg::desc_off) begin
                if (!s_reg.locked) begin
                    s_next.pattr = wdata[7:0];
                    s_next.pmax = wdata[15:8];
                    if (wdata[21:16] <= 6'(bridge_pkg::serial_max)) begin
                        s_next.ser_len = wdata[21:16];
                    end
                    if (wdata[30:24] <= 7'(bridge_pkg::desc_max)) begin
                        s_next.desc_len = wdata[30:24];
                    end
                    s_next.programmed = 1'b1;
                end
            end else if (addr == bridge_pkg::vid_off) begin
                if (!s_reg.locked) begin
                    s_next.vid = wdata[15:0];
                    s_next.pid = wdata[31:16];
                    s_next.programmed = 1'b1;
                end
            end else if (addr == bridge_pkg::lock_off) begin
                if (wdata[0]) begin
                    s_next.locked = 1'b1;
                end
            end
        end
        // register reads
        if (rd) begin
            if (addr == bridge_pkg::ctrl_off) begin
                s_next.rdata = {26'h0, s_reg.dtr, s_reg.rts, 2'b00, s_reg.asleep, s_reg.configured};
            end else if (addr == bridge_pkg::line_off) begin
                s_next.rdata = {23'h0, s_reg.line.flow, s_reg.line.parity, s_reg.line.stop, s_reg.line.len};
            end else if (addr == bridge_pkg::baud_off) begin
                s_next.rdata = {12'h0, s_reg.div};
            end else if (addr == bridge_pkg::data_off) begin
                s_next.rdata = {23'h0, s_reg.rvalid, s_reg.rdat};
                s_next.rvalid = 1'b0;
            end else if (addr == bridge_pkg::status_off) begin
                s_next.rdata = {22'h0, s_reg.pins, s_reg.paused, s_reg.rerr, s_reg.rvalid, s_reg.tfull, s_reg.locked};
                s_next.rerr = 1'b0;
            end else if (addr == bridge_pkg::gpio_off) begin
                s_next.rdata = {12'h0, s_reg.gpins, 4'h0, s_reg.gpio_d, 4'h0, s_reg.gpio_o};
            end else if (addr == bridge_pkg::desc_off) begin
                s_next.rdata = {1'b0, s_reg.desc_len, 2'b00, s_reg.ser_len, s_reg.pmax, s_reg.pattr};
            end else if (addr == bridge_pkg::lock_off) begin
                s_next.rdata = {30'h0, s_reg.programmed, s_reg.locked};
            end else if (addr == bridge_pkg::vid_off) begin
                s_next.rdata = {s_reg.pid, s_reg.vid};
            end
        end
        // transmitter
        s_next.tcnt = s_reg.tcnt + 20'h1;
        case (s_reg.tst)
            bridge_pkg::ser_idle: begin
                s_next.tline = 1'b1;
                s_next.tcnt = 20'h0;
                if (s_reg.tfull && tx_allow) begin
                    s_next.tsh = s_reg.thold;
                    s_next.tfull = 1'b0;
                    s_next.tpar = 1'b0;
                    s_next.tline = 1'b0;
                    s_next.tst = bridge_pkg::ser_start;
                end
            end
            bridge_pkg::ser_start: begin
                if (s_reg.tcnt >= s_reg.div - 20'h1) begin
                    s_next.tcnt = 20'h0;
                    s_next.tbit = 3'h0;
                    s_next.tline = s_reg.tsh[0];
                    s_next.tpar = s_reg.tsh[0];
                    s_next.tsh = {1'b0, s_reg.tsh[7:1]};
                    s_next.tst = bridge_pkg::ser_data;
                end
            end
            bridge_pkg::ser_data: begin
                if (s_reg.tcnt >= s_reg.div - 20'h1) begin
                    s_next.tcnt = 20'h0;
                    if (4'(s_reg.tbit) + 4'h1 == nbits) begin
                        s_next.thalf = 2'h0;
                        if (s_reg.line.parity == bridge_pkg::par_none) begin
                            s_next.tline = 1'b1;
                            s_next.tst = bridge_pkg::ser_stop;
                        end else begin
                            case (s_reg.line.parity)
                                bridge_pkg::par_even: s_next.tline = s_reg.tpar;
                                bridge_pkg::par_odd: s_next.tline = !s_reg.tpar;
                                bridge_pkg::par_mark: s_next.tline = 1'b1;
                                default: s_next.tline = 1'b0;
                            endcase
                            s_next.tst = bridge_pkg::ser_parity;
                        end
                    end else begin
                        s_next.tbit = s_reg.tbit + 3'h1;
                        s_next.tline = s_reg.tsh[0];
                        s_next.tpar = s_reg.tpar ^ s_reg.tsh[0];
                        s_next.tsh = {1'b0, s_reg.tsh[7:1]};
                    end
                end
            end
            bridge_pkg::ser_parity: begin
                if (s_reg.tcnt >= s_reg.div - 20'h1) begin
                    s_next.tcnt = 20'h0;
                    s_next.thalf = 2'h0;
                    s_next.tline = 1'b1;
                    s_next.tst = bridge_pkg::ser_stop;
                end
            end
            default: begin
                // stop time counted in half bits: 2, 3 or 4
                if (s_reg.tcnt >= (s_reg.div >> 1) - 20'h1) begin
                    s_next.tcnt = 20'h0;
                    s_next.thalf = s_reg.thalf + 2'h1;
                    case (s_reg.line.stop)
                        bridge_pkg::stop_one: stop_done = s_reg.thalf == 2'h1;
                        bridge_pkg::stop_one_half: stop_done = s_reg.thalf == 2'h2;
                        default: stop_done = s_reg.thalf == 2'h3;
                    endcase
                    if (stop_done) begin
                        s_next.tst = bridge_pkg::ser_idle;
                    end
                end
            end
        endcase
        // receiver samples mid-bit; a new char overwrites an unread one
        s_next.rcnt = s_reg.rcnt + 20'h1;
        case (s_reg.rst)
            bridge_pkg::ser_idle: begin
                s_next.rcnt = 20'h0;
                if (!s_reg.pins.rxd) begin
                    s_next.rst = bridge_pkg::ser_start;
                end
            end
            bridge_pkg::ser_start: begin
                if (s_reg.rcnt >= (s_reg.div >> 1)) begin
                    s_next.rcnt = 20'h0;
                    s_next.rbit = 3'h0;
                    s_next.rpar = 1'b0;
                    s_next.rst = s_reg.pins.rxd ? bridge_pkg::ser_idle : bridge_pkg::ser_data;
                end
            end
            bridge_pkg::ser_data: begin
                if (s_reg.rcnt >= s_reg.div - 20'h1) begin
                    s_next.rcnt = 20'h0;
                    s_next.rsh = {s_reg.pins.rxd, s_reg.rsh[7:1]};
                    s_next.rpar = s_reg.rpar ^ s_reg.pins.rxd;
                    s_next.rbit = s_reg.rbit + 3'h1;
                    if (4'(s_reg.rbit) + 4'h1 == nbits) begin
                        s_next.rst = (s_reg.line.parity == bridge_pkg::par_none)
                            ? bridge_pkg::ser_stop : bridge_pkg::ser_parity;
                    end
                end
            end
            bridge_pkg::ser_parity: begin
                if (s_reg.rcnt >= s_reg.div - 20'h1) begin
                    s_next.rcnt = 20'h0;
                    case (s_reg.line.parity)
                        bridge_pkg::par_even: s_next.rerr = s_reg.rerr | (s_reg.rpar ^ s_reg.pins.rxd);
                        bridge_pkg::par_odd: s_next.rerr = s_reg.rerr | !(s_reg.rpar ^ s_reg.pins.rxd);
                        bridge_pkg::par_mark: s_next.rerr = s_reg.rerr | !s_reg.pins.rxd;
                        default: s_next.rerr = s_reg.rerr | s_reg.pins.rxd;
                    endcase
                    s_next.rst = bridge_pkg::ser_stop;
                end
            end
            default: begin
                if (s_reg.rcnt >= s_reg.div - 20'h1) begin
                    s_next.rst = bridge_pkg::ser_idle;
                    if (!s_reg.pins.rxd) begin
                        s_next.rerr = 1'b1;
                    end else if (s_reg.line.flow == bridge_pkg::flow_xon_xoff
                                 && (s_reg.rsh >> (4'h8 - nbits)) == bridge_pkg::xoff_char) begin
                        s_next.paused = 1'b1;
                    end else if (s_reg.line.flow == bridge_pkg::flow_xon_xoff
                                 && (s_reg.rsh >> (4'h8 - nbits)) == bridge_pkg::xon_char) begin
                        s_next.paused = 1'b0;
                    end else begin
                        s_next.rdat = s_reg.rsh >> (4'h8 - nbits);
                        s_next.rvalid = 1'b1;
                    end
                end
            end
        endcase
        if (s_reg.line.flow != bridge_pkg::flow_xon_xoff) begin
            s_next.paused = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_reg <= '0;
            s_reg.asleep <= 1'b1;
            s_reg.div <= 20'(bridge_pkg::baud_div_reset);
            s_reg.line.len <= 2'h3;
            s_reg.vid <= vid_default;
            s_reg.pid <= pid_default;
            s_reg.pattr <= bridge_pkg::def_power_attr;
            s_reg.pmax <= bridge_pkg::def_max_power;
            s_reg.tline <= 1'b1;
            s_reg.sync <= '1;
            s_reg.pins <= '1;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs
    assign rdata = s_reg.rdata;
    assign txd = s_reg.tline;
    assign rts_n = !s_reg.rts;
    assign dtr_n = !s_reg.dtr;
    // an external pull-down is needed to hold the complement low while in reset
    assign suspend_out = s_reg.asleep;
    assign suspend_n_out = !s_reg.asleep;
    assign suspend_oe = !reset;
    assign suspend_n_oe = !reset;
    assign gpio_out = s_reg.gpio_o;
    assign gpio_oe = s_reg.gpio_d;
endmodule : usb_uart_bridge_core

// file: bridge_pkg.sv
// shared constants and carrier types for the serial bridge core
package bridge_pkg;
    // register map (word index = byte address / 4)
    localparam logic [7:0] ctrl_off = 8'h00;
    localparam logic [7:0] line_off = 8'h04;
    localparam logic [7:0] baud_off = 8'h08;
    localparam logic [7:0] data_off = 8'h0c;
    localparam logic [7:0] status_off = 8'h10;
    localparam logic [7:0] gpio_off = 8'h14;
    localparam logic [7:0] desc_off = 8'h18;
    localparam logic [7:0] lock_off = 8'h1c;
    localparam logic [7:0] vid_off = 8'h20;
    // line field positions
    localparam int len_lsb = 0;
    localparam int stop_lsb = 2;
    localparam int par_lsb = 4;
    localparam int flow_lsb = 7;
    // control bits
    localparam int ctl_config_done = 0;
    localparam int ctl_suspend = 1;
    localparam int ctl_resume = 2;
    localparam int ctl_bus_reset = 3;
    localparam int ctl_rts = 4;
    localparam int ctl_dtr = 5;
    // descriptor defaults and length limits
    localparam logic [7:0] def_power_attr = 8'h80;
    localparam logic [7:0] def_max_power = 8'h32;
    localparam int serial_max = 63;
    localparam int desc_max = 126;
    // flow characters
    localparam logic [7:0] xon_char = 8'h11;
    localparam logic [7:0] xoff_char = 8'h13;
    // timing
    localparam int clk_hz = 20000000;
    localparam int baud_fast = 921600;
    localparam int baud_reset = 115200;
    localparam int baud_div_reset = clk_hz / baud_reset;
    localparam int reset_low_us = 15;

    typedef enum logic [1:0] {
        stop_one = 2'b00,
        stop_one_half = 2'b01,
        stop_two = 2'b10
    } stop_t;

    typedef enum logic [2:0] {
        par_none = 3'b000,
        par_even = 3'b001,
        par_odd = 3'b010,
        par_mark = 3'b011,
        par_space = 3'b100
    } parity_t;

    typedef enum logic [1:0] {
        flow_off = 2'b00,
        flow_rts_cts = 2'b01,
        flow_dsr_dtr = 2'b10,
        flow_xon_xoff = 2'b11
    } flow_t;

    typedef enum logic [2:0] {
        ser_idle = 3'b000,
        ser_start = 3'b001,
        ser_data = 3'b010,
        ser_parity = 3'b011,
        ser_stop = 3'b100
    } ser_t;

    typedef struct packed {
        logic [1:0] len;
        stop_t stop;
        parity_t parity;
        flow_t flow;
    } line_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef struct packed {
        logic rxd;
        logic cts_n;
        logic dsr_n;
        logic dcd_n;
        logic ri_n;
    } modem_in_t;
endpackage : bridge_pkg

// file: usb_uart_bridge_core_checker.sv
// port assertions for the serial bridge core
`timescale 1ns/1ps
module usb_uart_bridge_core_checker #(
    parameter int gpio_w = 4
) (
    // clock, reset, register port
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    // serial port
    input wire logic txd,
    input wire logic rxd,
    input wire logic cts_n,
    input wire logic rts_n,
    input wire logic dsr_n,
    input wire logic dtr_n,
    input wire logic dcd_n,
    input wire logic ri_n,
    // sleep and gpio pins
    input wire logic suspend_out,
    input wire logic suspend_oe,
    input wire logic suspend_n_out,
    input wire logic suspend_n_oe,
    input wire logic [gpio_w-1:0] gpio_in,
    input wire logic [gpio_w-1:0] gpio_out,
    input wire logic [gpio_w-1:0] gpio_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic ctl_wr;
    assign ctl_wr = wr && addr == bridge_pkg::ctrl_off;
    // checked on the release edge, since the pins are meant to float all through reset
    float_in_reset_a: assert property ($fell(reset) |-> !$past(suspend_oe) && !$past(suspend_n_oe))
        else $error("pin driven");
    pins_opposed_a: assert property (suspend_oe && suspend_n_oe |-> suspend_n_out != suspend_out)
        else $error("pins equal");
    asleep_reset_a: assert property ($fell(reset) |-> suspend_out && !suspend_n_out)
        else $error("awake at reset");
    enter_sleep_a: assert property (ctl_wr && wdata[1] && wdata[3:2] == 0 && !wdata[0] |-> ##[1:2] suspend_out)
        else $error("no sleep");
    wake_config_a: assert property (ctl_wr && wdata[0] && !wdata[1] |-> ##[1:2] !suspend_out)
        else $error("no wake");
    modem_out_a: assert property (ctl_wr |=> rts_n == !$past(wdata[4]) && dtr_n == !$past(wdata[5]))
        else $error("modem out");
    gpio_drive_a: assert property (wr && addr == bridge_pkg::gpio_off |=> gpio_out == $past(wdata[gpio_w-1:0])
        && gpio_oe == $past(wdata[gpio_w+7:8])) else $error("gpio");
    read_quiet_a: assert property (!$past(rd) |-> rdata == '0) else $error("rdata not zero");
    start_bit_a: assert property ($fell(txd) |-> !txd [*8]) else $error("start bit short");
    cover property (ctl_wr && wdata[1]);
    cover property ($fell(txd));
    cover property ($fell(suspend_out));
endmodule : usb_uart_bridge_core_checker

// file: serial_peer.sv
// serial peripheral model: sends 8n1 on rxd, captures txd frames, drives modem inputs
`timescale 1ns/1ps
module serial_peer #(
    parameter int div = 20
) (
    // clock and lines
    input wire logic clk,
    input wire logic txd,
    output logic rxd,
    output logic cts_n,
    output logic dsr_n,
    output logic dcd_n,
    output logic ri_n
);
    logic [9:0] frame;
    int frames = 0;
    initial begin
        rxd = 1'b1;
        {cts_n, dsr_n, dcd_n, ri_n} = 4'hf;
    end
    task automatic lines(input logic [3:0] v);
        @(posedge clk);
        {cts_n, dsr_n, dcd_n, ri_n} <= v;
    endtask : lines
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            rxd <= f[i];
            repeat (div - 1) @(posedge clk);
        end
    endtask : send
    // samples mid-bit; two bits after the data cover parity and stop
    always begin
        @(negedge txd);
        repeat (div / 2) @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            repeat (div) @(posedge clk);
            frame[i] = txd;
        end
        frames++;
    end
endmodule : serial_peer

// file: usb_uart_bridge_core_bench.sv
// self-checking bench for the serial bridge core
`timescale 1ns/1ps
module usb_uart_bridge_core_bench;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [3:0] gpio_in = 4'h0;
    logic [31:0] rdata, d;
    logic txd, rxd, cts_n, rts_n, dsr_n, dtr_n, dcd_n, ri_n;
    logic suspend_out, suspend_oe, suspend_n_out, suspend_n_oe;
    logic [3:0] gpio_out, gpio_oe;
    logic [3:0] sl[5] = '{4'h1, 4'h2, 4'h4, 4'h2, 4'h8};
    logic [1:0] pe[5] = '{2'b11, 2'b10, 2'b11, 2'b11, 2'b10};
    int failures = 0;
    int checks = 0;
    int cyc = 0;
    int n;
    always #25 clk = ~clk;
    usb_uart_bridge_core i_usb_uart_bridge_core (.*);
    serial_peer #(.div(20)) i_serial_peer (.*);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wt(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : wt
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    task automatic get_frame(input logic [9:0] exp);
        n = i_serial_peer.frames;
        for (int i = 0; i < 600 && i_serial_peer.frames == n; i++) @(posedge clk);
        chk(i_serial_peer.frames - n, 1);
        chk(i_serial_peer.frame, exp);
    endtask : get_frame
    task automatic stop_test;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test
    // a hang is cut well past the longest expected run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            stop_test();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        rd_reg(bridge_pkg::ctrl_off);
        chk(d, 32'h2);
        rd_reg(bridge_pkg::line_off);
        chk(d, 32'h3);
        rd_reg(bridge_pkg::desc_off);
        chk(d & 32'hffff, 32'h3280);
        rd_reg(8'h40);
        chk(d, 32'h0);
        chk({suspend_out, suspend_n_out, txd, rts_n, dtr_n}, 5'b10111);
        foreach (sl[i]) begin
            wr_reg(bridge_pkg::ctrl_off, {28'h0, sl[i]});
            wt(2);
            chk({suspend_out, suspend_n_out}, {i[0], ~i[0]});
        end
        wr_reg(bridge_pkg::ctrl_off, 32'h11);
        wt(2);
        chk({rts_n, dtr_n, suspend_out}, 3'b010);
        wr_reg(bridge_pkg::ctrl_off, 32'h21);
        wt(2);
        chk({rts_n, dtr_n}, 2'b10);
        gpio_in <= 4'h9;
        wr_reg(bridge_pkg::gpio_off, 32'h0a05);
        wt(6);
        chk({gpio_oe, gpio_out}, 8'ha5);
        rd_reg(bridge_pkg::gpio_off);
        chk(d[19:16], 4'h9);
        wr_reg(bridge_pkg::baud_off, 32'd20);
        for (int p = 0; p < 5; p++) begin
            wr_reg(bridge_pkg::line_off, 32'h3 | p << 4);
            wr_reg(bridge_pkg::data_off, 32'ha6);
            get_frame({pe[p], 8'ha6});
        end
        wr_reg(bridge_pkg::line_off, 32'h1);
        wr_reg(bridge_pkg::baud_off, 32'd21);
        rd_reg(bridge_pkg::baud_off);
        chk(d, 32'd20);
        wr_reg(bridge_pkg::line_off, 32'h4);
        wr_reg(bridge_pkg::data_off, 32'h15);
        get_frame(10'h3f5);
        wr_reg(bridge_pkg::line_off, 32'h7);
        rd_reg(bridge_pkg::line_off);
        chk(d, 32'h3);
        wr_reg(bridge_pkg::line_off, 32'hf);
        rd_reg(bridge_pkg::line_off);
        chk(d, 32'hb);
        wr_reg(bridge_pkg::line_off, 32'h83);
        wr_reg(bridge_pkg::data_off, 32'h3c);
        n = i_serial_peer.frames;
        wt(300);
        chk(i_serial_peer.frames - n, 0);
        i_serial_peer.lines(4'h7);
        get_frame({2'b11, 8'h3c});
        wr_reg(bridge_pkg::line_off, 32'h103);
        wr_reg(bridge_pkg::data_off, 32'h69);
        n = i_serial_peer.frames;
        wt(300);
        chk(i_serial_peer.frames - n, 0);
        i_serial_peer.lines(4'h2);
        get_frame({2'b11, 8'h69});
        wr_reg(bridge_pkg::line_off, 32'h183);
        i_serial_peer.send(bridge_pkg::xoff_char);
        wr_reg(bridge_pkg::data_off, 32'h55);
        n = i_serial_peer.frames;
        wt(300);
        chk(i_serial_peer.frames - n, 0);
        rd_reg(bridge_pkg::status_off);
        chk(d[4], 1'b1);
        chk(d[9:5], 5'h12);
        i_serial_peer.send(bridge_pkg::xon_char);
        get_frame({2'b11, 8'h55});
        i_serial_peer.send(8'h5c);
        wt(8);
        rd_reg(bridge_pkg::data_off);
        chk(d[8:0], 9'h15c);
        rd_reg(bridge_pkg::data_off);
        chk(d[8], 1'b0);
        wr_reg(bridge_pkg::desc_off, 32'h64c0);
        rd_reg(bridge_pkg::desc_off);
        chk(d & 32'hffff, 32'h64c0);
        wr_reg(bridge_pkg::lock_off, 32'h1);
        wr_reg(bridge_pkg::desc_off, 32'ha0);
        rd_reg(bridge_pkg::desc_off);
        chk(d & 32'hffff, 32'h64c0);
        rd_reg(bridge_pkg::lock_off);
        chk(d[1:0], 2'b11);
        reset <= 1'b1;
        wt(bridge_pkg::reset_low_us * (bridge_pkg::clk_hz / 1000000));
        chk({suspend_oe, suspend_n_oe}, 2'b00);
        reset <= 1'b0;
        wt(2);
        chk({suspend_oe, suspend_n_oe, suspend_out, suspend_n_out}, 4'b1110);
        stop_test();
    end
endmodule : usb_uart_bridge_core_bench
bind usb_uart_bridge_core usb_uart_bridge_core_checker #(.gpio_w(gpio_w)) i_usb_uart_bridge_core_checker (.*);
